// File: shared/ccr_pkg.sv
// Package for the clock configuration register bank: offsets, fields, defaults.
// Assumes an APB master with 32-bit data; register N sits at byte address 4*N.
// Operation
// - Every configuration field loads its default at reset or on soft reset.
// - Register 0 bit 17 is soft reset; writing one reloads all defaults.
// - Register 1 bit 17 is global power-down, default zero meaning active.
// - Registers 0-5 bit 31 power down a group; groups d and e default normal.
// - Bit 30 of registers 3 and 4 selects source; group d oscillator, e VCO.
// - Registers 0-5 bits 28,29 are analog delay selects, default zero.
// - Registers 0-5 bit 16 is half shift, default zero.
// - Registers 0-5 bits 15:5 hold divide; default 25, group d default 1.
// - Registers 6-8 hold 4-bit output formats; output 6 defaults to 8.
// - Readback words are 27 bits; register 12 lock pin select at 26:22.
// - Register 12 readback returns latch enable where a zero is written.
package ccr_pkg;
	localparam int NUM_REGS = 32;
	localparam int RB_WIDTH = 27;
	localparam logic [4:0] IDX_R0 = 5'h00;
	localparam logic [4:0] IDX_R1 = 5'h01;
	localparam logic [4:0] IDX_R3 = 5'h03;
	localparam logic [4:0] IDX_R4 = 5'h04;
	localparam logic [4:0] IDX_R5 = 5'h05;
	localparam logic [4:0] IDX_R6 = 5'h06;
	localparam logic [4:0] IDX_R7 = 5'h07;
	localparam logic [4:0] IDX_R12 = 5'h0C;
	localparam logic [4:0] IDX_R23 = 5'h17;
	localparam logic [4:0] IDX_R31 = 5'h1F;
	// Extra register of our own: readback data window
	localparam logic [11:0] ADDR_RB_DATA = 12'h080;
	localparam int BIT_GROUP_PD = 31;
	localparam int BIT_SRC_SEL = 30;
	localparam int BIT_ADLY_HI = 29;
	localparam int BIT_ADLY_LO = 28;
	localparam int BIT_SOFT_RST = 17;
	localparam int BIT_POWERDOWN = 17;
	localparam int BIT_HALF_SHIFT = 16;
	localparam int BIT_RB_LE = 21;
	localparam int BIT_WRITE_LOCK = 5;
	localparam int RB_ADDR_LSB = 16;
	// Defaults for registers 0..5 (divide 25 is 11'h019 at 15:5)
	localparam logic [31:0] DEF_GRP_PD = 32'h80000320;
	localparam logic [31:0] DEF_R3 = 32'h40000020; // Normal, oscillator, divide 1
	localparam logic [31:0] DEF_R4 = 32'h00000320; // Normal, VCO, divide 25
	localparam logic [31:0] DEF_R7 = 32'h08000000; // Output 6 format 8 at 27:24
	localparam logic [31:0] DEF_R12 = 32'h18000000; // Lock pin select 3 at 31:27
	localparam logic [31:0] DEF_ZERO = 32'h00000000;
	typedef logic [31:0] ccr_word_t;
endpackage

// File: shared/ccr_wr_if.sv
// Internal write port between APB slave and register store.
// Assumes a single clock shared by both sides.
`timescale 1ns/100ps
interface ccr_wr_if;
	logic we;
	logic [4:0] idx;
	logic [31:0] wdata;
	modport src (output we, idx, wdata);
	modport dst (input we, idx, wdata);
endinterface

// File: hw/ccr_regfile.sv
// Register store with per-register defaults and soft reset.
// Assumes writes arrive as single-cycle strobes on the write interface.
`timescale 1ns/100ps
module ccr_regfile
	import ccr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	ccr_wr_if.dst wr,
	output logic [31:0] regs_o [NUM_REGS]
);
	typedef struct packed {
		logic [NUM_REGS-1:0][31:0] r;
	} ccr_rf_state_t;
	ccr_rf_state_t s_q, s_d;

	function automatic ccr_word_t def_of(input int i);
		ccr_word_t v;
		v = DEF_ZERO;
		if (i <= 5) v = DEF_GRP_PD;
		if (i == 3) v = DEF_R3;
		if (i == 4) v = DEF_R4;
		if (i == 7) v = DEF_R7;
		if (i == 12) v = DEF_R12;
		return v;
	endfunction

	// Soft reset in register 0 reloads everything; the bit itself self-clears
	always_comb begin
		s_d = s_q;
		if (s_q.r[0][BIT_SOFT_RST]) begin
			for (int i = 0; i < NUM_REGS; i++) s_d.r[i] = def_of(i);
		end else if (wr.we) begin
			s_d.r[wr.idx] = wr.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_REGS; i++) s_q.r[i] <= def_of(i);
		end else begin
			s_q <= s_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++) begin : g_out
			assign regs_o[g] = s_q.r[g];
		end
	endgenerate

	soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.r[0][BIT_SOFT_RST] |=> (s_q.r[3] == DEF_R3 && s_q.r[7] == DEF_R7))
		else $error("soft reset did not reload defaults");
	write_store_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wr.we && !s_q.r[0][BIT_SOFT_RST]) |=> s_q.r[$past(wr.idx)] == $past(wr.wdata))
		else $error("write not stored");
endmodule // ccr_regfile

// File: hw/ccr_readback.sv
// Builds the 27-bit readback word for the register picked by register 31.
// Assumes the register array is stable registered state.
`timescale 1ns/100ps
module ccr_readback
	import ccr_pkg::*;
(
	input logic [31:0] regs_i [NUM_REGS],
	output logic [RB_WIDTH-1:0] rb_o
);
	logic [4:0] sel;
	ccr_word_t w;
	// Data field 31:5 maps to readback 26:0
	always_comb begin
		sel = regs_i[IDX_R31][RB_ADDR_LSB+4:RB_ADDR_LSB];
		w = regs_i[sel];
		rb_o = w[31:5];
		if (sel == IDX_R12) begin
			rb_o[26:22] = w[31:27];
			rb_o[16] = regs_i[IDX_R31][BIT_RB_LE];
		end else if (sel == IDX_R31) begin
			rb_o = {26'h0, w[BIT_WRITE_LOCK]};
		end else if (sel == IDX_R23) begin
			rb_o = {3'h0, w[28:19], 14'h0};
		end
	end
endmodule // ccr_readback

// File: hw/ccr_top.sv
// Top of the clock configuration register bank with an APB slave port.
// Assumes APB master on SYS_CLK; zero-wait slave, PREADY high in access.
`timescale 1ns/100ps
module ccr_top
	import ccr_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic DEVICE_POWERDOWN,
	output logic [5:0] GROUP_POWERDOWN,
	output logic [5:0] GROUP_HALF_SHIFT
);
	import ccr_pkg::*;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic pwr_dn;
		logic [5:0] grp_pd;
		logic [5:0] grp_hs;
	} ccr_top_state_t;
	ccr_top_state_t s_q, s_d;

	ccr_wr_if wr();
	logic [31:0] regs [NUM_REGS];
	logic [RB_WIDTH-1:0] rb_word;
	logic setup;
	logic mapped;
	logic locked;

	ccr_regfile u_rf (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.wr(wr),
		.regs_o(regs)
	);

	ccr_readback u_rb (
		.regs_i(regs),
		.rb_o(rb_word)
	);

	// Decode: word registers at 0x000..0x07C plus readback window
	assign setup = PSEL && !PENABLE;
	assign mapped = (PADDR[1:0] == 2'h0) && (PADDR[11:7] == 5'h00 || PADDR == ADDR_RB_DATA);
	// Write lock blocks writes to all but register 31, so it can be unlocked
	assign locked = regs[IDX_R31][BIT_WRITE_LOCK] && (PADDR[6:2] != IDX_R31);
	// Write lands at the access edge where PREADY is seen high, as the master expects
	assign wr.we = PSEL && PENABLE && s_q.pready && PWRITE && mapped && PADDR[11:7] == 5'h00
		&& !locked;
	assign wr.idx = PADDR[6:2];
	assign wr.wdata = PWDATA;

	// Answer next cycle (access phase) with data captured at setup
	always_comb begin
		s_d = s_q;
		s_d.pready = setup;
		s_d.pslverr = setup && (!mapped || (PWRITE && locked));
		if (setup && !PWRITE && mapped) begin
			s_d.prdata = (PADDR == ADDR_RB_DATA) ? {5'h00, rb_word} : regs[PADDR[6:2]];
		end else if (setup) begin
			s_d.prdata = 32'h00000000;
		end
		s_d.pwr_dn = regs[IDX_R1][BIT_POWERDOWN];
		for (int i = 0; i < 6; i++) begin
			s_d.grp_pd[i] = regs[i][BIT_GROUP_PD];
			s_d.grp_hs[i] = regs[i][BIT_HALF_SHIFT];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign PRDATA = s_q.prdata;
	assign PREADY = s_q.pready;
	assign PSLVERR = s_q.pslverr;
	assign DEVICE_POWERDOWN = s_q.pwr_dn;
	assign GROUP_POWERDOWN = s_q.grp_pd;
	assign GROUP_HALF_SHIFT = s_q.grp_hs;

	pd_follow_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		##1 DEVICE_POWERDOWN == $past(regs[IDX_R1][BIT_POWERDOWN]))
		else $error("power-down output mismatch");
	grp_pd_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		##1 GROUP_POWERDOWN[3] == $past(regs[IDX_R3][BIT_GROUP_PD]))
		else $error("group power-down mismatch");
	half_shift_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		##1 GROUP_HALF_SHIFT[0] == $past(regs[IDX_R0][BIT_HALF_SHIFT]))
		else $error("half shift mismatch");
	adly_def_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(regs[IDX_R0][BIT_SOFT_RST]) |=> ##1 regs[IDX_R5][BIT_ADLY_HI:BIT_ADLY_LO] == 2'h0)
		else $error("analog delay default wrong");
	div_def_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(regs[IDX_R0][BIT_SOFT_RST]) |=> ##1 regs[IDX_R3][15:5] == 11'h001)
		else $error("divide default wrong");
	src_def_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(regs[IDX_R0][BIT_SOFT_RST]) |=> ##1
		(regs[IDX_R3][BIT_SRC_SEL] && !regs[IDX_R4][BIT_SRC_SEL]))
		else $error("source select default wrong");
	fmt_def_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(regs[IDX_R0][BIT_SOFT_RST]) |=> ##1
		(regs[IDX_R7][27:24] == 4'h8 && regs[IDX_R6] == 32'h00000000))
		else $error("format default wrong");
	rb_le_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(regs[IDX_R31][20:16] == IDX_R12) |-> rb_word[16] == regs[IDX_R31][BIT_RB_LE])
		else $error("latch enable not returned");
	rb_mux_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(regs[IDX_R31][20:16] == IDX_R12) |-> rb_word[26:22] == regs[IDX_R12][31:27])
		else $error("lock pin select readback wrong");
	apb_ready_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(PSEL && !PENABLE) |=> PREADY)
		else $error("no ready in access phase");
endmodule // ccr_top

// File: bench/ccr_host.sv
// APB master model standing in for the host controller.
// Assumes one clock; the bench calls xfer through the instance.
`timescale 1ns/100ps
module ccr_host (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Idle bus from time zero
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// One transfer, held unchanged until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Released address and data flip, so a stale value never passes as valid
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // ccr_host

// File: bench/ccr_top_tb.sv
// Self-checking bench for the clock configuration register bank.
// Assumes the host model drives the APB port; one 100 MHz clock.
`timescale 1ns/100ps
module ccr_top_tb;
	import ccr_pkg::*;
	logic SYS_CLK;
	logic RST_N;
	logic PSEL;
	logic PENABLE;
	logic PWRITE;
	logic [11:0] PADDR;
	logic [31:0] PWDATA;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic DEVICE_POWERDOWN;
	logic [5:0] GROUP_POWERDOWN;
	logic [5:0] GROUP_HALF_SHIFT;
	int n_fail;
	int n_checks;
	logic [31:0] seed;
	logic [31:0] r;
	logic e;

	// Clock of 10 ns
	initial begin
		SYS_CLK = 1'h0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	ccr_top dut_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .DEVICE_POWERDOWN(DEVICE_POWERDOWN),
		.GROUP_POWERDOWN(GROUP_POWERDOWN), .GROUP_HALF_SHIFT(GROUP_HALF_SHIFT));
	ccr_host host_u (.clk(SYS_CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
		.paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY),
		.pslverr(PSLVERR));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	// Default word: groups d and e run, d from oscillator at divide 1
	function automatic logic [31:0] dflt(input int i);
		if (i == 3) return 32'h40000020;
		if (i == 4) return 32'h00000320;
		if (i < 6) return 32'h80000320;
		if (i == 7) return 32'h08000000;
		if (i == 12) return 32'h18000000;
		return 32'h0;
	endfunction

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Registers 0 to 8 and 12 against their defaults, plus the pins
	task automatic chk_defaults;
		for (int i = 0; i < 13; i++) begin
			if (i > 8 && i != 12) continue;
			host_u.xfer(1'h0, 12'(4 * i), 32'h0, r, e);
			chk("default", r, dflt(i));
		end
		chk("group pd", 32'(GROUP_POWERDOWN), 32'h27);
		chk("half shift", 32'(GROUP_HALF_SHIFT), 32'h0);
		chk("device pd", 32'(DEVICE_POWERDOWN), 32'h0);
	endtask

	// Watchdog, far beyond the roughly 130 cycles the tests need
	initial begin
		#50000;
		n_fail++;
		finish_test();
	end

	// Main sequence
	initial begin
		RST_N = 1'h0;
		n_fail = 0;
		n_checks = 0;
		seed = 32'h397B99BF;
		repeat (3) @(posedge SYS_CLK);
		RST_N <= 1'h1;
		chk_defaults();
		// Random words into registers 1 to 5 reach the control pins
		for (int k = 1; k < 6; k++) begin
			seed = xs(seed);
			host_u.xfer(1'h1, 12'(4 * k), seed, r, e);
			host_u.xfer(1'h0, 12'(4 * k), 32'h0, r, e);
			chk("reg", r, seed);
			chk("hs", 32'(GROUP_HALF_SHIFT[k]), 32'(seed[16]));
			chk("gpd", 32'(GROUP_POWERDOWN[k]), 32'(seed[31]));
			if (k == 1) chk("dpd", 32'(DEVICE_POWERDOWN), 32'(seed[17]));
		end
		// Soft reset must bring the defaults of registers 0 to 8 and 12 back
		host_u.xfer(1'h1, 12'h000, 32'h00020000, r, e);
		chk_defaults();
		// Register 12 readback with latch enable off, then on
		for (int le = 0; le < 2; le++) begin
			host_u.xfer(1'h1, 12'h07C, 32'h000C0000 | (32'(le) << 21), r, e);
			host_u.xfer(1'h0, 12'h080, 32'h0, r, e);
			chk("rb12", r, 32'h00C00000 | (32'(le) << 16));
		end
		// Lock writes, read register 31 back, then see a locked write refused
		host_u.xfer(1'h1, 12'h07C, 32'h001F0020, r, e);
		host_u.xfer(1'h0, 12'h080, 32'h0, r, e);
		chk("rb31", r, 32'h1);
		host_u.xfer(1'h1, 12'h008, 32'h0, r, e);
		chk("lock err", 32'(e), 32'h1);
		host_u.xfer(1'h0, 12'h008, 32'h0, r, e);
		chk("locked reg", r, dflt(2));
		host_u.xfer(1'h1, 12'h07C, 32'h0, r, e);
		chk("unlock err", 32'(e), 32'h0);
		// Unmapped and misaligned addresses are refused
		host_u.xfer(1'h0, 12'h084, 32'h0, r, e);
		chk("unmapped err", 32'(e), 32'h1);
		host_u.xfer(1'h1, 12'h006, 32'h0, r, e);
		chk("misaligned err", 32'(e), 32'h1);
		finish_test();
	end
endmodule // ccr_top_tb
